// ---- rtl/xlg_pkg.sv ----
// Shared constants, types and lane mapping helpers for the lane gearbox
// Behaviour
// (R1) Separate transmit and receive paths, 36 pins each
// (R2) Four lanes: eight data bits, one control
// (R3) Octets fill lanes in fixed round-robin order
// (R4) Characters flow on every transfer, no gaps
// (R5) Parallel word splits into even/odd shift registers
// (R6) Even/odd streams drive DDR pins, clock forwarded
// (R7) Input pin captured both edges, even/odd split
// (R8) Input shifts on received clock into 8-bit word
// (R9) Word held on divide-by-4 clock for core
// (R10) Output shifter clocked by divided transmit clock
// (R11) Pin structure replicated for all 36 pins
// (R12) Each direction has its own clock generator
// (R13) Link clock at most 156.25 MHz, DDR
// (R14) Lane zero holds bits 7:0 and control 0
// (R15) Reset clears shifters, pins show idle character; transmit shifters load the idle pattern, receive shifters clear
package xlg_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int XLG_LANES     = 4;
  localparam int XLG_LANE_BITS = 8;
  localparam int XLG_NDATA     = XLG_LANES * XLG_LANE_BITS;  // 32
  localparam int XLG_NCTRL     = XLG_LANES;                  // 4
  localparam int XLG_NPINS     = XLG_NDATA + XLG_NCTRL;      // 36
  localparam int XLG_XFERS     = 8;   // Bits per pin word
  localparam int XLG_HALF      = XLG_XFERS / 2;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int XLG_CLK_SYS_HZ  = 10_000_000;
  localparam int XLG_LINK_MAX_HZ = 156_250_000;
  // One link clock period spans two system cycles: high half carries
  // the even bit, low half the odd bit.
  localparam int XLG_CYC_PER_LINK = 2;
  localparam int XLG_LINK_HZ      = XLG_CLK_SYS_HZ / XLG_CYC_PER_LINK;
  localparam logic [2:0] XLG_PH_FIRST = 3'h0;
  localparam logic [2:0] XLG_PH_LAST  = 3'h7;

  // ------------------------------------------------------------------
  // Idle character
  // ------------------------------------------------------------------
  localparam logic [7:0] XLG_IDLE_BYTE = 8'h07;
  localparam logic       XLG_IDLE_CTRL = 1'b1;

  typedef logic [XLG_XFERS-1:0][XLG_NDATA-1:0] xlg_data_t;
  typedef logic [XLG_XFERS-1:0][XLG_NCTRL-1:0] xlg_ctrl_t;
  typedef logic [XLG_XFERS-1:0]                xlg_pinw_t;
  typedef logic [XLG_HALF-1:0]                 xlg_half_t;

  // Pin p < 32 is data bit p of lane p/8, else control bit p-32;
  // bit k of the pin word is transfer k
  function automatic xlg_pinw_t xlg_pin_word(input xlg_data_t d,
                                             input xlg_ctrl_t c,
                                             input int p);
    xlg_pinw_t w;
    w = '0;
    for (int k = 0; k < XLG_XFERS; k++) begin
      w[k] = (p < XLG_NDATA) ? d[k][p] : c[k][p-XLG_NDATA]; // R14 R3
    end
    return w;
  endfunction : xlg_pin_word

  function automatic xlg_pinw_t xlg_idle_word(input int p);
    return (p < XLG_NDATA) ? {XLG_XFERS{XLG_IDLE_BYTE[p % XLG_LANE_BITS]}}
                           : {XLG_XFERS{XLG_IDLE_CTRL}};
  endfunction : xlg_idle_word

  function automatic xlg_half_t xlg_even(input xlg_pinw_t w);
    xlg_half_t h;
    h = '0;
    for (int j = 0; j < XLG_HALF; j++) begin
      h[j] = w[2*j];
    end
    return h;
  endfunction : xlg_even

  function automatic xlg_half_t xlg_odd(input xlg_pinw_t w);
    xlg_half_t h;
    h = '0;
    for (int j = 0; j < XLG_HALF; j++) begin
      h[j] = w[2*j+1];
    end
    return h;
  endfunction : xlg_odd

  function automatic xlg_pinw_t xlg_merge(input xlg_half_t e,
                                          input xlg_half_t o);
    xlg_pinw_t w;
    w = '0;
    for (int j = 0; j < XLG_HALF; j++) begin
      w[2*j]   = e[j];
      w[2*j+1] = o[j];
    end
    return w;
  endfunction : xlg_merge

endpackage : xlg_pkg

// ---- rtl/xlg_link_if.sv ----
// Pin-level link between the MAC reconciliation end and the PHY end
`timescale 1ns/1ns
interface xlg_link_if;
  // MAC to PHY direction
  logic                          mac_side_transmit_clock;
  logic                          m2p_sync;
  logic [xlg_pkg::XLG_NPINS-1:0] m2p_d;
  // PHY to MAC direction
  logic                          p2m_clk;
  logic                          p2m_sync;
  logic [xlg_pkg::XLG_NPINS-1:0] p2m_d;

  modport phy (
    input  mac_side_transmit_clock,
    input  m2p_sync,
    input  m2p_d,
    output p2m_clk,
    output p2m_sync,
    output p2m_d
  );

  modport mac (
    output mac_side_transmit_clock,
    output m2p_sync,
    output m2p_d,
    input  p2m_clk,
    input  p2m_sync,
    input  p2m_d
  );
endinterface : xlg_link_if

// ---- rtl/xlg_phy_end.sv ----
// PHY end: DDR serialiser toward the MAC and DDR deserialiser from it
`timescale 1ns/1ns
module xlg_phy_end (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  xlg_link_if.phy                 link,
  input  wire xlg_pkg::xlg_data_t out_data,
  input  wire xlg_pkg::xlg_ctrl_t out_ctrl,
  input  wire logic               out_valid,
  output logic                    out_ready,
  output xlg_pkg::xlg_data_t      in_data,
  output xlg_pkg::xlg_ctrl_t      in_ctrl,
  output logic                    in_valid,
  output logic                    in_div_clk
);

  // ------------------------------------------------------------------
  // Output clock generator (toward the MAC)
  // ------------------------------------------------------------------
  // Own phase counter for this direction; the receive path below keeps
  // a separate one locked to the MAC's clock.
  logic [2:0] tph_r;
  logic       tclk_r;
  logic       tsync_r;

  always_ff @(posedge clk_sys or negedge resetn) begin // R12
    if (!resetn) begin
      tph_r <= xlg_pkg::XLG_PH_FIRST;
    end else begin
      tph_r <= tph_r + 3'h1; // R10
    end
  end

  // Link clock is high while the even bit stands, low for the odd bit,
  // so the data pin changes on both of its edges.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tclk_r <= 1'b0;
    end else begin
      tclk_r <= ~tph_r[0]; // R6 R13
    end
  end

  // Sync covers the first link clock period of every pin word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tsync_r <= 1'b0;
    end else begin
      tsync_r <= (tph_r[2:1] == 2'h0);
    end
  end

  assign link.p2m_clk  = tclk_r; // R6
  assign link.p2m_sync = tsync_r;

  // Word is taken in the last phase; with no word offered the idle
  // character goes out so the link never gaps.
  assign out_ready = (tph_r == xlg_pkg::XLG_PH_LAST); // R4

  // ------------------------------------------------------------------
  // Receive phase tracking (from the MAC)
  // ------------------------------------------------------------------
  logic [2:0] rph_r;
  logic [2:0] rph;
  logic       rstart;
  logic       rlock_r;
  logic       rvalid_r;
  logic       rdiv_r;
  logic       rlast;

  // Sync with the clock high marks the first even bit of a word
  assign rstart = link.m2p_sync && link.mac_side_transmit_clock;
  assign rph    = rstart ? xlg_pkg::XLG_PH_FIRST : rph_r;
  assign rlast  = (rph == xlg_pkg::XLG_PH_LAST);

  // Phase restarts on every sync so a slipped word realigns
  always_ff @(posedge clk_sys or negedge resetn) begin // R12
    if (!resetn) begin
      rph_r <= xlg_pkg::XLG_PH_FIRST;
    end else begin
      rph_r <= rph + 3'h1;
    end
  end

  // Words before the first sync are partial and are not reported
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rlock_r <= 1'b0;
    end else if (rstart) begin
      rlock_r <= 1'b1;
    end
  end

  // Valid pulses once per assembled word, only after lock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rlast && rlock_r; // R9
    end
  end

  // Divided clock rises with each new word and stays high four cycles
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdiv_r <= 1'b0;
    end else begin
      rdiv_r <= rlast || (rph < 3'h3); // R9
    end
  end

  assign in_valid   = rvalid_r;
  assign in_div_clk = rdiv_r; // R9

  // ------------------------------------------------------------------
  // Per-pin serialiser and deserialiser
  // ------------------------------------------------------------------
  for (genvar p = 0; p < xlg_pkg::XLG_NPINS; p++) begin : g_pin // R11
    // Idle pattern this pin shows in reset and in unoffered slots
    localparam xlg_pkg::xlg_pinw_t IW = xlg_pkg::xlg_idle_word(p);
    xlg_pkg::xlg_pinw_t w;
    xlg_pkg::xlg_half_t we;
    xlg_pkg::xlg_half_t wo;
    xlg_pkg::xlg_half_t se_r;
    xlg_pkg::xlg_half_t so_r;
    logic               pin_r;
    xlg_pkg::xlg_half_t re_r;
    xlg_pkg::xlg_half_t ro_r;
    xlg_pkg::xlg_half_t ro_last;
    xlg_pkg::xlg_pinw_t hold_r;

    assign w = out_valid ? xlg_pkg::xlg_pin_word(out_data, out_ctrl, p)
                         : IW; // R4

    // Even transfers feed one shifter, odd transfers the other
    for (genvar j = 0; j < xlg_pkg::XLG_HALF; j++) begin : g_split
      assign we[j] = w[2*j];
      assign wo[j] = w[2*j+1];
    end

    // Shifters load in the last phase and move on odd phases 1, 3 and 5
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        se_r <= xlg_pkg::xlg_even(IW); // R15
      end else if (tph_r == xlg_pkg::XLG_PH_LAST) begin
        se_r <= we; // R5
      end else if (tph_r[0]) begin
        se_r <= {1'b0, se_r[xlg_pkg::XLG_HALF-1:1]}; // R5
      end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        so_r <= xlg_pkg::xlg_odd(IW); // R15
      end else if (tph_r == xlg_pkg::XLG_PH_LAST) begin
        so_r <= wo; // R5
      end else if (tph_r[0]) begin
        so_r <= {1'b0, so_r[xlg_pkg::XLG_HALF-1:1]}; // R5
      end
    end

    // DDR output stage: even bit in the high half, odd in the low half
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pin_r <= IW[0]; // R15
      end else begin
        pin_r <= tph_r[0] ? so_r[0] : se_r[0]; // R6
      end
    end

    assign link.p2m_d[p] = pin_r;

    // Capture steered by the received clock level
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        re_r <= '0; // R15
      end else if (link.mac_side_transmit_clock) begin
        re_r <= {link.m2p_d[p], re_r[xlg_pkg::XLG_HALF-1:1]}; // R7 R8
      end
    end

    // Odd transfers arrive while the received clock is low
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        ro_r <= '0; // R15
      end else if (!link.mac_side_transmit_clock) begin
        ro_r <= {link.m2p_d[p], ro_r[xlg_pkg::XLG_HALF-1:1]}; // R7 R8
      end
    end

    // Last odd bit goes straight into the holding register
    assign ro_last = {link.m2p_d[p], ro_r[xlg_pkg::XLG_HALF-1:1]};

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        hold_r <= '0; // R15
      end else if (rlast) begin
        hold_r <= xlg_pkg::xlg_merge(re_r, ro_last); // R9
      end
    end

    for (genvar k = 0; k < xlg_pkg::XLG_XFERS; k++) begin : g_xfer
      if (p < xlg_pkg::XLG_NDATA) begin : g_d
        assign in_data[k][p] = hold_r[k]; // R14
      end else begin : g_c
        assign in_ctrl[k][p-xlg_pkg::XLG_NDATA] = hold_r[k]; // R2
      end
    end
  end

endmodule : xlg_phy_end

// ---- rtl/xlg_mac_end.sv ----
// MAC reconciliation end: drives the transmit link, receives from PHY
`timescale 1ns/1ns
module xlg_mac_end (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  xlg_link_if.mac                 link,
  input  wire xlg_pkg::xlg_data_t tx_data,
  input  wire xlg_pkg::xlg_ctrl_t tx_ctrl,
  input  wire logic               tx_valid,
  output logic                    tx_ready,
  output xlg_pkg::xlg_data_t      rx_data,
  output xlg_pkg::xlg_ctrl_t      rx_ctrl,
  output logic                    rx_valid,
  output logic                    rx_div_clk
);

  // ------------------------------------------------------------------
  // Transmit clock generator
  // ------------------------------------------------------------------
  logic [2:0] tph_r;
  logic       tclk_r;
  logic       tsync_r;

  always_ff @(posedge clk_sys or negedge resetn) begin // R1
    if (!resetn) begin
      tph_r <= xlg_pkg::XLG_PH_FIRST;
    end else begin
      tph_r <= tph_r + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tclk_r  <= 1'b0;
      tsync_r <= 1'b0;
    end else begin
      tclk_r  <= ~tph_r[0]; // R13
      tsync_r <= (tph_r[2:1] == 2'h0);
    end
  end

  assign link.mac_side_transmit_clock = tclk_r;
  assign link.m2p_sync                = tsync_r;
  // Idle fills any word the user does not offer, keeping the flow
  assign tx_ready = (tph_r == xlg_pkg::XLG_PH_LAST); // R4

  // ------------------------------------------------------------------
  // Receive phase tracking
  // ------------------------------------------------------------------
  logic [2:0] rph_r;
  logic [2:0] rph;
  logic       rlock_r;
  logic       rvalid_r;
  logic       rdiv_r;
  logic       rlast;

  assign rph   = (link.p2m_sync && link.p2m_clk)
                 ? xlg_pkg::XLG_PH_FIRST : rph_r;
  assign rlast = (rph == xlg_pkg::XLG_PH_LAST);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rph_r <= xlg_pkg::XLG_PH_FIRST;
    end else begin
      rph_r <= rph + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rlock_r <= 1'b0;
    end else if (link.p2m_sync && link.p2m_clk) begin
      rlock_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdiv_r   <= 1'b0;
    end else begin
      rvalid_r <= rlast && rlock_r; // R4
      rdiv_r   <= rlast || (rph < 3'h3);
    end
  end

  assign rx_valid   = rvalid_r;
  assign rx_div_clk = rdiv_r;

  // ------------------------------------------------------------------
  // Per-pin lane logic
  // ------------------------------------------------------------------
  for (genvar p = 0; p < xlg_pkg::XLG_NPINS; p++) begin : g_pin // R2
    localparam xlg_pkg::xlg_pinw_t IW = xlg_pkg::xlg_idle_word(p);
    xlg_pkg::xlg_pinw_t w;
    xlg_pkg::xlg_half_t se_r;
    xlg_pkg::xlg_half_t so_r;
    logic               pin_r;
    xlg_pkg::xlg_half_t re_r;
    xlg_pkg::xlg_half_t ro_r;
    xlg_pkg::xlg_pinw_t hold_r;

    assign w = tx_valid ? xlg_pkg::xlg_pin_word(tx_data, tx_ctrl, p)
                        : IW; // R3 R14

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        se_r <= xlg_pkg::xlg_even(IW);
        so_r <= xlg_pkg::xlg_odd(IW);
      end else if (tph_r == xlg_pkg::XLG_PH_LAST) begin
        se_r <= xlg_pkg::xlg_even(w);
        so_r <= xlg_pkg::xlg_odd(w);
      end else if (tph_r[0]) begin
        se_r <= {1'b0, se_r[xlg_pkg::XLG_HALF-1:1]};
        so_r <= {1'b0, so_r[xlg_pkg::XLG_HALF-1:1]};
      end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        pin_r <= IW[0];
      end else begin
        pin_r <= tph_r[0] ? so_r[0] : se_r[0]; // R13
      end
    end

    assign link.m2p_d[p] = pin_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        re_r <= '0;
        ro_r <= '0;
      end else if (link.p2m_clk) begin
        re_r <= {link.p2m_d[p], re_r[xlg_pkg::XLG_HALF-1:1]};
      end else begin
        ro_r <= {link.p2m_d[p], ro_r[xlg_pkg::XLG_HALF-1:1]};
      end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        hold_r <= '0;
      end else if (rlast) begin
        hold_r <= xlg_pkg::xlg_merge(re_r,
                    {link.p2m_d[p], ro_r[xlg_pkg::XLG_HALF-1:1]});
      end
    end

    for (genvar k = 0; k < xlg_pkg::XLG_XFERS; k++) begin : g_xfer
      if (p < xlg_pkg::XLG_NDATA) begin : g_d
        assign rx_data[k][p] = hold_r[k]; // R14
      end else begin : g_c
        assign rx_ctrl[k][p-xlg_pkg::XLG_NDATA] = hold_r[k];
      end
    end
  end

endmodule : xlg_mac_end

// ---- tb/xlg_link_assertions.sv ----
// Link checker watching both directions of the lane gearbox wires
`timescale 1ns/1ns
module xlg_link_assertions (
  input wire logic                          clk_sys,
  input wire logic                          resetn,
  input wire logic                          mac_side_transmit_clock,
  input wire logic                          m2p_sync,
  input wire logic [xlg_pkg::XLG_NPINS-1:0] m2p_d,
  input wire logic                          p2m_clk,
  input wire logic                          p2m_sync,
  input wire logic [xlg_pkg::XLG_NPINS-1:0] p2m_d
);
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam logic [35:0] IDLE_P = {4'hF, 32'h0707_0707};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_M_CLK_TOGGLE: assert property ($past(resetn) |->
    mac_side_transmit_clock != $past(mac_side_transmit_clock))
    else $error("tx link clock stuck");
  AST_P_CLK_TOGGLE: assert property ($past(resetn) |->
    p2m_clk != $past(p2m_clk))
    else $error("rx link clock stuck");
  AST_M_SYNC_EVEN: assert property (
    m2p_sync && mac_side_transmit_clock |=>
    m2p_sync && !mac_side_transmit_clock)
    else $error("tx word start not on clock high");
  AST_P_SYNC_EVEN: assert property (
    p2m_sync && p2m_clk |=> p2m_sync && !p2m_clk)
    else $error("rx word start not on clock high");
  AST_M_SYNC_PERIOD: assert property (
    $rose(m2p_sync) |-> m2p_sync[*2] ##1 !m2p_sync[*6] ##1 m2p_sync)
    else $error("tx word spacing wrong");
  AST_P_SYNC_PERIOD: assert property (
    $rose(p2m_sync) |-> p2m_sync[*2] ##1 !p2m_sync[*6] ##1 p2m_sync)
    else $error("rx word spacing wrong");
  AST_M_RESET_IDLE: assert property (disable iff (1'b0)
    !resetn[*2] |-> m2p_d == IDLE_P && !m2p_sync &&
    !mac_side_transmit_clock)
    else $error("tx pins not idle in reset");
  AST_P_RESET_IDLE: assert property (disable iff (1'b0)
    !resetn[*2] |-> p2m_d == IDLE_P && !p2m_sync && !p2m_clk)
    else $error("rx pins not idle in reset");
endmodule : xlg_link_assertions

// ---- tb/tb_top.sv ----
// Self-checking bench joining both ends of the lane gearbox
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [287:0] IDLE_W = {{32{xlg_pkg::XLG_IDLE_CTRL}},
                                     {32{xlg_pkg::XLG_IDLE_BYTE}}};
  localparam logic [35:0]  IDLE_P = {{4{xlg_pkg::XLG_IDLE_CTRL}},
                                     {4{xlg_pkg::XLG_IDLE_BYTE}}};
  logic               clk_sys = 1'b0;
  logic               resetn  = 1'b0;
  xlg_pkg::xlg_data_t tx_data, out_data, rx_data, in_data;
  xlg_pkg::xlg_ctrl_t tx_ctrl, out_ctrl, rx_ctrl, in_ctrl;
  logic               tx_valid, out_valid, tx_ready, out_ready;
  logic               rx_valid, in_valid, rx_div_clk, in_div_clk;
  logic [287:0]       eq[2][$];
  int                 dq[2][$];
  logic               pdiv[2];
  logic [287:0]       lastw[2];
  int                 fail_count = 0;
  int                 cmp_count  = 0;
  int                 cyc        = 0;

  xlg_link_if lnk ();
  xlg_mac_end u_xlg_mac_end (.clk_sys(clk_sys), .resetn(resetn),
    .link(lnk), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_ctrl(rx_ctrl), .rx_valid(rx_valid), .rx_div_clk(rx_div_clk));
  xlg_phy_end u_xlg_phy_end (.clk_sys(clk_sys), .resetn(resetn),
    .link(lnk), .out_data(out_data), .out_ctrl(out_ctrl),
    .out_valid(out_valid), .out_ready(out_ready), .in_data(in_data),
    .in_ctrl(in_ctrl), .in_valid(in_valid), .in_div_clk(in_div_clk));
  xlg_link_assertions u_xlg_link_assertions (.clk_sys(clk_sys),
    .resetn(resetn), .mac_side_transmit_clock(lnk.mac_side_transmit_clock),
    .m2p_sync(lnk.m2p_sync), .m2p_d(lnk.m2p_d), .p2m_clk(lnk.p2m_clk),
    .p2m_sync(lnk.p2m_sync), .p2m_d(lnk.p2m_d));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [287:0] seen,
                     input logic [287:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // Lanes get distinct bytes so a swapped lane or pin shows up
  function automatic logic [287:0] mkw(input int i);
    logic [287:0] w;
    for (int k = 0; k < 8; k++) begin
      w[32*k +: 32]    = 32'h0123_4567 * (i + 3) + k * 32'h1357_9BDF;
      w[256+4*k +: 4]  = 4'(i * 5 + k);
    end
    return w;
  endfunction : mkw

  // Direction 0 runs MAC to PHY, direction 1 PHY to MAC
  task automatic send(input int d, input logic [287:0] w, input logic v);
    logic [287:0] e;
    logic [287:0] b;
    int           n;
    int           j;
    e = v ? w : IDLE_W;
    n = 0;
    if (d == 0) begin
      {tx_ctrl, tx_data} = w;
      tx_valid = v;
    end else begin
      {out_ctrl, out_data} = w;
      out_valid = v;
    end
    while (((d == 0) ? tx_ready : out_ready) !== 1'b1 && n < 12) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("ready", n < 12, 1'b1);
    @(posedge clk_sys);
    #1;
    eq[d].push_back(e);
    dq[d].push_back(cyc + 9);
    for (int k = 0; k < 8; k++) begin
      // Pins trail the take by one edge: prior word's bit 7 shows first
      b = (k == 0) ? lastw[d] : e;
      j = (k + 7) % 8;
      chk("pins", (d == 0) ? lnk.m2p_d : lnk.p2m_d,
          {b[256+4*j +: 4], b[32*j +: 32]});
      chk("link clk", (d == 0) ? lnk.mac_side_transmit_clock
                               : lnk.p2m_clk, k[0]);
      if (k < 7) begin
        @(posedge clk_sys);
        #1;
      end
    end
    lastw[d] = e;
  endtask : send

  // ----------------------------------------------------------------
  // Clock, timeout and receive monitor
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 1000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    pdiv = '{1'b0, 1'b0};
    forever begin
      @(posedge clk_sys);
      #2;
      for (int d = 0; d < 2; d++) begin
        if (dq[d].size() > 0 && dq[d][0] == cyc) begin
          chk("word", (d == 0) ? {in_ctrl, in_data}
                               : {rx_ctrl, rx_data}, eq[d][0]);
          chk("valid div", (d == 0) ? {in_valid, pdiv[0], in_div_clk}
              : {rx_valid, pdiv[1], rx_div_clk}, 3'b101);
          void'(eq[d].pop_front());
          void'(dq[d].pop_front());
        end
        pdiv[d] = (d == 0) ? in_div_clk : rx_div_clk;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    tx_valid  = 1'b0;
    out_valid = 1'b0;
    tx_data   = '0;
    out_data  = '0;
    tx_ctrl   = '0;
    out_ctrl  = '0;
    lastw     = '{IDLE_W, IDLE_W};
    repeat (20) @(posedge clk_sys);
    #1 resetn = 1'b1;
    // Both directions at once, back to back, one idle gap
    fork
      for (int i = 0; i < 8; i++) send(0, (i == 2) ? '0 : (i == 5) ? '1
                                       : mkw(i), i != 4);
      for (int i = 0; i < 8; i++) send(1, (i == 3) ? '1 : (i == 6) ? '0
                                       : mkw(i + 9), i != 1);
    join
    tx_valid  = 1'b0;
    out_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("reset outs", {in_valid, rx_valid, in_div_clk, rx_div_clk,
        out_ready, tx_ready, |in_data, |rx_data, |in_ctrl, |rx_ctrl},
        10'h000);
    chk("reset tx pins", lnk.m2p_d, IDLE_P);
    chk("reset rx pins", lnk.p2m_d, IDLE_P);
    resetn = 1'b1;
    lastw  = '{IDLE_W, IDLE_W};
    fork
      send(0, mkw(20), 1'b1);
      send(1, mkw(21), 1'b1);
    join
    tx_valid  = 1'b0;
    out_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    chk("pending", dq[0].size() + dq[1].size(), 0);
    stop_test();
  end
endmodule : tb_top
